/* bench/pwt_top_bench.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Directed bench for the waveform block
// ----------------------------------------------------------------
module pwt_top_bench;
  // Stimulus and observed signals
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  enable_i;
  logic [7:0]  polarity_i;
  logic [7:0]  align_i;
  logic [3:0]  concat_i;
  logic [63:0] period_i;
  logic [63:0] duty_i;
  logic [7:0]  pwm_o;
  logic [63:0] count_o;
  logic [7:0]  count_up_o;
  int          failures;
  int          n_checks;

  pwt_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i), .polarity_i(polarity_i), .align_i(align_i),
    .concat_i(concat_i), .period_i(period_i), .duty_i(duty_i), .pwm_o(pwm_o), .count_o(count_o),
    .count_up_o(count_up_o));

  // 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Shared compare; four-state so an unknown never matches
  task check_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  // Whole periods are counted, so the phase at the start does not matter
  // Unknown pin levels are counted apart so they can never pass as low
  task count_pin(input int ch, input int n, input int expv);
    int hits;
    int unk;
    hits = 0;
    unk  = 0;
    repeat (n)
    begin
      @(negedge clk_i);
      if (pwm_o[ch] === 1'b1) hits++;
      else if (pwm_o[ch] !== 1'b0) unk++;
    end
    check_val($sformatf("pwm_o[%0d] active cycles", ch), 64'(expv), 64'(hits));
    check_val($sformatf("pwm_o[%0d] unknown cycles", ch), 64'h0, 64'(unk));
  endtask : count_pin

  task t_left;
    count_pin(0, 8, 2);
    count_pin(1, 10, 6);
    count_pin(5, 6, 0);
    count_pin(6, 6, 6);
    $display("test left done");
  endtask : t_left

  task t_center;
    count_pin(4, 16, 6);
    $display("test center done");
  endtask : t_center

  task t_join;
    count_pin(3, 512, 256);
    count_pin(2, 512, 0);
    // Joined pair in center mode: period 512, active 2*128-1 cycles
    align_i[3] = 1'b1;
    repeat (2) @(negedge clk_i);
    count_pin(3, 1024, 510);
    count_pin(2, 16, 0);
    $display("test join done");
  endtask : t_join

  task t_idle;
    count_pin(7, 8, 0);
    check_val("count_o ch7", 64'h0, 64'(count_o[63:56]));
    $display("test idle done");
  endtask : t_idle

  // Polarity change while running is taken without restart
  task t_flip;
    polarity_i[0] = 1'b0;
    repeat (2) @(negedge clk_i);
    count_pin(0, 8, 6);
    $display("test flip done");
  endtask : t_flip

  task t_reset;
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check_val("pwm_o in reset", 64'h0, 64'(pwm_o));
    check_val("count_o in reset", 64'h0, count_o);
    check_val("count_up_o in reset", 64'h00ff, 64'(count_up_o));
    rst_i = 1'b0;
    // First two edges after release: counters restart from zero
    @(negedge clk_i);
    check_val("count_o ch0 after reset", 64'h1, 64'(count_o[7:0]));
    check_val("pwm_o[6] after reset", 64'h1, 64'(pwm_o[6]));
    @(negedge clk_i);
    check_val("count_o ch4 after reset", 64'h2, 64'(count_o[39:32]));
    check_val("count_up_o after reset", 64'h00ff, 64'(count_up_o));
    $display("test reset done");
  endtask : t_reset

  task final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // Main sequence; one setting covers every channel mode at once except joined center, which t_join sets later
  initial
  begin
    failures   = 0;
    n_checks   = 0;
    rst_i      = 1'b1;
    enable_i   = 8'h7b;
    polarity_i = 8'hf9;
    align_i    = 8'h10;
    concat_i   = 4'h2;
    period_i   = 64'h0303_0304_0100_0504;
    duty_i     = 64'h0103_0002_0080_0201;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    t_left();
    t_center();
    t_join();
    t_idle();
    t_flip();
    t_reset();
    final_report();
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk_i);
    failures++;
    final_report();
  end
endmodule : pwt_top_bench

/* bench/pwt_top_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the waveform block
// ----------------------------------------------------------------
module pwt_top_chk
(
  // Clock and reset
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_i,
  // Controls
  input  wire logic [pwt_pkg::NUM_CH-1:0]                enable_i,
  input  wire logic [pwt_pkg::NUM_CH-1:0]                polarity_i,
  input  wire logic [pwt_pkg::NUM_CH-1:0]                align_i,
  input  wire logic [pwt_pkg::NUM_PAIR-1:0]              concat_i,
  input  wire logic [pwt_pkg::NUM_CH*pwt_pkg::CNT_W-1:0] period_i,
  input  wire logic [pwt_pkg::NUM_CH*pwt_pkg::CNT_W-1:0] duty_i,
  // Outputs under watch
  input  wire logic [pwt_pkg::NUM_CH-1:0]                pwm_o,
  input  wire logic [pwt_pkg::NUM_CH*pwt_pkg::CNT_W-1:0] count_o,
  input  wire logic [pwt_pkg::NUM_CH-1:0]                count_up_o
);
  // Byte views; only channels 0, 4, 7 and pair 1 are watched to keep this cheap
  wire logic [7:0]  c0  = count_o[7:0];
  wire logic [7:0]  c4  = count_o[39:32];
  wire logic [7:0]  c7  = count_o[63:56];
  wire logic [7:0]  p0  = period_i[7:0];
  wire logic [7:0]  d0  = duty_i[7:0];
  wire logic [7:0]  p4  = period_i[39:32];
  wire logic [7:0]  d4  = duty_i[39:32];
  wire logic [15:0] w1  = count_o[31:16];
  wire logic [15:0] pw1 = period_i[31:16];
  wire logic        l0  = enable_i[0] && !align_i[0] && !concat_i[0];
  wire logic        m4  = enable_i[4] && align_i[4] && !concat_i[2] && p4 > 8'h01;
  wire logic        j1  = concat_i[1] && enable_i[3] && !align_i[3] && pw1 != 16'h0000;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_left_count: assert property (l0 && p0 != 8'h00 |=> c0 == (($past(c0) >= $past(p0) - 8'h01) ? 8'h00 : $past(c0) + 8'h01))
    else $error("left counter step wrong");
  chk_left_level: assert property (l0 |=> pwm_o[0] ==
    ((($past(d0) != 8'h00) && (($past(d0) >= $past(p0)) || ($past(c0) < $past(d0))))
     ? $past(polarity_i[0]) : !$past(polarity_i[0])))
    else $error("left pin level wrong");
  chk_left_dir: assert property (l0 |=> count_up_o[0])
    else $error("left counter not counting up");
  chk_center_top: assert property (m4 && c4 == p4 && $past(c4) == p4 - 8'h01 |=> c4 == $past(p4) - 8'h01)
    else $error("center counter did not turn at period");
  chk_center_floor: assert property (m4 && c4 == 8'h00 && $past(c4) == 8'h01 |=> c4 == 8'h01)
    else $error("center counter did not turn at zero");
  chk_center_level: assert property (m4 |=> pwm_o[4] ==
    ((($past(d4) != 8'h00) && (($past(d4) >= $past(p4)) || ($past(c4) < $past(d4))))
     ? $past(polarity_i[4]) : !$past(polarity_i[4])))
    else $error("center pin level wrong");
  chk_join_low: assert property (concat_i[1] |=> pwm_o[2] == !$past(polarity_i[3]))
    else $error("joined low pin not inactive");
  chk_join_step: assert property (j1 && w1 < pw1 - 16'h0001 |=> w1 == $past(w1) + 16'h0001)
    else $error("joined counter step wrong");
  chk_idle_off: assert property (!enable_i[7] && !concat_i[3] |=> pwm_o[7] == !$past(polarity_i[7]) && c7 == 8'h00)
    else $error("disabled channel not idle");

  // Main scenarios reached
  cover property (m4 && c4 == p4);
  cover property (j1 && w1 == pw1 - 16'h0001);
  cover property (l0 && c0 == 8'h00 && pwm_o[0]);
endmodule : pwt_top_chk

bind pwt_top pwt_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i), .polarity_i(polarity_i),
  .align_i(align_i), .concat_i(concat_i), .period_i(period_i), .duty_i(duty_i), .pwm_o(pwm_o),
  .count_o(count_o), .count_up_o(count_up_o));

/* core/pwt_pkg.sv */
package pwt_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH   = 8;   // Eight waveform channels
  localparam int NUM_PAIR = 4;   // Channel pairs that may be joined
  localparam int CNT_W    = 8;   // Width of one channel counter
  localparam int WIDE_W   = 16;  // Width of a joined channel

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;
  localparam logic [WIDE_W-1:0] WIDE_ONE = 16'h0001;
  localparam logic [WIDE_W-1:0] WIDE_ZRO = 16'h0000;
  localparam logic              DIR_UP   = 1'b1;   // Counting direction after reset

  // ----------------------------------------------------------------
  // Alignment encoding of the align_i bits
  // ----------------------------------------------------------------
  typedef enum logic [0:0]
  {
    PWT_LEFT   = 1'b0,
    PWT_CENTER = 1'b1
  } pwt_align_t;

endpackage : pwt_pkg

/* core/pwt_top.sv */
`timescale 1ns/1ps
// Eight-channel pulse width modulator with pair concatenation.
module pwt_top
(
  // Clock and reset
  input  wire logic                                          clk_i,
  input  wire logic                                          rst_i,
  // Per-channel control, bit n belongs to channel n
  input  wire logic [pwt_pkg::NUM_CH-1:0]                    enable_i,
  input  wire logic [pwt_pkg::NUM_CH-1:0]                    polarity_i,
  input  wire logic [pwt_pkg::NUM_CH-1:0]                    align_i,
  // Pair join, bit k joins channels 2k+1 (high byte) and 2k (low byte)
  input  wire logic [pwt_pkg::NUM_PAIR-1:0]                  concat_i,
  // Period and duty, byte n belongs to channel n
  input  wire logic [pwt_pkg::NUM_CH*pwt_pkg::CNT_W-1:0]     period_i,
  input  wire logic [pwt_pkg::NUM_CH*pwt_pkg::CNT_W-1:0]     duty_i,
  // Waveform pins
  output logic      [pwt_pkg::NUM_CH-1:0]                    pwm_o,
  // Status: counter values and counting direction
  output logic      [pwt_pkg::NUM_CH*pwt_pkg::CNT_W-1:0]     count_o,
  output logic      [pwt_pkg::NUM_CH-1:0]                    count_up_o
);

  // ----------------------------------------------------------------
  // Counter step
  // ----------------------------------------------------------------
  // Shared by the 8-bit and the joined 16-bit counters.
  // Returns {direction, next count}.
  function automatic logic [pwt_pkg::WIDE_W:0] step
  (
    input logic [pwt_pkg::WIDE_W-1:0] cnt,
    input logic [pwt_pkg::WIDE_W-1:0] per,
    input logic                       up,
    input logic                       center
  );
    logic [pwt_pkg::WIDE_W-1:0] nc;
    logic                       nd;
    nc = cnt;
    nd = up;
    if (!center)
    begin
      // Left aligned: 0 .. period-1, then wrap; pulse opens the period
      nd = pwt_pkg::DIR_UP;
      if ((cnt + pwt_pkg::WIDE_ONE) >= per)
        nc = pwt_pkg::WIDE_ZRO;
      else
        nc = cnt + pwt_pkg::WIDE_ONE;
    end
    else if (up)
    begin
      // Center aligned: turn round at the period value
      if (cnt >= per)
      begin
        nd = !pwt_pkg::DIR_UP;
        nc = (cnt == pwt_pkg::WIDE_ZRO) ? pwt_pkg::WIDE_ZRO : cnt - pwt_pkg::WIDE_ONE;
      end
      else
        nc = cnt + pwt_pkg::WIDE_ONE;
    end
    else
    begin
      // Down leg ends at zero; pulse is centred on this turning point
      if (cnt == pwt_pkg::WIDE_ZRO)
      begin
        nd = pwt_pkg::DIR_UP;
        nc = (per == pwt_pkg::WIDE_ZRO) ? pwt_pkg::WIDE_ZRO : pwt_pkg::WIDE_ONE;
      end
      else
        nc = cnt - pwt_pkg::WIDE_ONE;
    end
    step = {nd, nc};
  endfunction : step

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [pwt_pkg::CNT_W-1:0] cnt      [pwt_pkg::NUM_CH];
  logic [pwt_pkg::CNT_W-1:0] next_cnt [pwt_pkg::NUM_CH];
  logic                      dir      [pwt_pkg::NUM_CH];
  logic                      next_dir [pwt_pkg::NUM_CH];
  logic [pwt_pkg::NUM_CH-1:0] lvl;
  logic [pwt_pkg::NUM_CH-1:0] next_pwm;

  // ----------------------------------------------------------------
  // Channel pairs
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < pwt_pkg::NUM_PAIR; k = k + 1)
    begin : g_pair
      localparam int LO = 2 * k;
      localparam int HI = 2 * k + 1;

      logic [pwt_pkg::CNT_W-1:0]  per_lo;
      logic [pwt_pkg::CNT_W-1:0]  per_hi;
      logic [pwt_pkg::CNT_W-1:0]  duty_lo;
      logic [pwt_pkg::CNT_W-1:0]  duty_hi;
      logic [pwt_pkg::WIDE_W-1:0] w_per_lo;
      logic [pwt_pkg::WIDE_W-1:0] w_per_hi;
      logic [pwt_pkg::WIDE_W-1:0] w_duty_lo;
      logic [pwt_pkg::WIDE_W-1:0] w_duty_hi;
      logic [pwt_pkg::WIDE_W-1:0] w_cnt_lo;
      logic [pwt_pkg::WIDE_W-1:0] w_cnt_hi;
      logic                       en_hi;
      logic                       en_lo;
      logic                       pol_lo;
      logic                       pol_hi;
      logic [pwt_pkg::WIDE_W:0]   s_lo;
      logic [pwt_pkg::WIDE_W:0]   s_hi;
      logic [pwt_pkg::WIDE_W:0]   s_wide;

      assign per_lo  = period_i[LO*pwt_pkg::CNT_W +: pwt_pkg::CNT_W];
      assign per_hi  = period_i[HI*pwt_pkg::CNT_W +: pwt_pkg::CNT_W];
      assign duty_lo = duty_i[LO*pwt_pkg::CNT_W +: pwt_pkg::CNT_W];
      assign duty_hi = duty_i[HI*pwt_pkg::CNT_W +: pwt_pkg::CNT_W];

      // Operand selection: joined pairs take the high channel's controls
      always_comb
      begin
        if (concat_i[k])
        begin
          w_per_hi  = {per_hi, per_lo};
          w_duty_hi = {duty_hi, duty_lo};
          w_cnt_hi  = {cnt[HI], cnt[LO]};
          en_hi     = enable_i[HI];
          en_lo     = 1'b0;          // Low pin idles at inactive level
          pol_hi    = polarity_i[HI];
          pol_lo    = polarity_i[HI];
        end
        else
        begin
          w_per_hi  = {8'h00, per_hi};
          w_duty_hi = {8'h00, duty_hi};
          w_cnt_hi  = {8'h00, cnt[HI]};
          en_hi     = enable_i[HI];
          en_lo     = enable_i[LO];
          pol_hi    = polarity_i[HI];
          pol_lo    = polarity_i[LO];
        end
        w_per_lo  = {8'h00, per_lo};
        w_duty_lo = {8'h00, duty_lo};
        w_cnt_lo  = {8'h00, cnt[LO]};
      end

      // Next counter values for both channels of the pair
      always_comb
      begin
        s_lo   = step(w_cnt_lo, w_per_lo, dir[LO], align_i[LO]);
        s_hi   = step(w_cnt_hi, w_per_hi, dir[HI], align_i[HI]);
        s_wide = step(w_cnt_hi, w_per_hi, dir[HI], align_i[HI]);
        if (concat_i[k])
        begin
          // One 16-bit counter spread over both byte counters
          if (en_hi)
          begin
            next_cnt[HI] = s_wide[pwt_pkg::WIDE_W-1:pwt_pkg::CNT_W];
            next_cnt[LO] = s_wide[pwt_pkg::CNT_W-1:0];
            next_dir[HI] = s_wide[pwt_pkg::WIDE_W];
          end
          else
          begin
            next_cnt[HI] = pwt_pkg::CNT_RST;
            next_cnt[LO] = pwt_pkg::CNT_RST;
            next_dir[HI] = pwt_pkg::DIR_UP;
          end
          next_dir[LO] = pwt_pkg::DIR_UP;
        end
        else
        begin
          // Each byte counter runs alone, held at zero while disabled
          next_cnt[HI] = en_hi ? s_hi[pwt_pkg::CNT_W-1:0] : pwt_pkg::CNT_RST;
          next_dir[HI] = en_hi ? s_hi[pwt_pkg::WIDE_W] : pwt_pkg::DIR_UP;
          next_cnt[LO] = en_lo ? s_lo[pwt_pkg::CNT_W-1:0] : pwt_pkg::CNT_RST;
          next_dir[LO] = en_lo ? s_lo[pwt_pkg::WIDE_W] : pwt_pkg::DIR_UP;
        end
      end

      // Compare stages
      pwt_wave u_wave_hi
      (
        .en_i   (en_hi),
        .pol_i  (pol_hi),
        .per_i  (w_per_hi),
        .duty_i (w_duty_hi),
        .cnt_i  (w_cnt_hi),
        .lvl_o  (lvl[HI])
      );

      pwt_wave u_wave_lo
      (
        .en_i   (en_lo),
        .pol_i  (pol_lo),
        .per_i  (w_per_lo),
        .duty_i (w_duty_lo),
        .cnt_i  (w_cnt_lo),
        .lvl_o  (lvl[LO])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Pins are registered so they are glitch free; costs one cycle of lag
  always_comb
  begin
    next_pwm = lvl;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Period and duty are used as presented, with no double buffering,
  // so a change mid-period can shorten or stretch that one period.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int n = 0; n < pwt_pkg::NUM_CH; n++)
      begin
        cnt[n] <= pwt_pkg::CNT_RST;
        dir[n] <= pwt_pkg::DIR_UP;
      end
      pwm_o <= 8'h00;
    end
    else
    begin
      for (int n = 0; n < pwt_pkg::NUM_CH; n++)
      begin
        cnt[n] <= next_cnt[n];
        dir[n] <= next_dir[n];
      end
      pwm_o <= next_pwm;
    end
  end

  // Status mirrors, registered from the same next values
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_o    <= 64'h0000_0000_0000_0000;
      count_up_o <= 8'hFF;
    end
    else
    begin
      for (int n = 0; n < pwt_pkg::NUM_CH; n++)
      begin
        count_o[n*pwt_pkg::CNT_W +: pwt_pkg::CNT_W] <= next_cnt[n];
        count_up_o[n]                               <= next_dir[n];
      end
    end
  end

endmodule : pwt_top

/* core/pwt_wave.sv */
`timescale 1ns/1ps
// Turns one counter value into the active/inactive level of a channel.
module pwt_wave
(
  // Channel settings
  input  wire logic                         en_i,
  input  wire logic                         pol_i,
  input  wire logic [pwt_pkg::WIDE_W-1:0]   per_i,
  input  wire logic [pwt_pkg::WIDE_W-1:0]   duty_i,
  // Counter state
  input  wire logic [pwt_pkg::WIDE_W-1:0]   cnt_i,
  // Pin level
  output logic                              lvl_o
);

  logic active;

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  // Zero duty never goes active; duty at or above period always does while enabled
  always_comb
  begin
    active = en_i && (duty_i != pwt_pkg::WIDE_ZRO) &&
             ((duty_i >= per_i) || (cnt_i < duty_i));
    lvl_o  = pol_i ? active : !active;
  end

endmodule : pwt_wave
